// File: rtl/fac_top.sv
// Digital coding path of an 8-bit flash converter
// Overview of operation
// - Sample taken only on strobe rising edge
// - Output lags its sample by one strobe
// - Output word held between strobe pulses
// - Bit 7 is MSB, bit 0 LSB
// - Thermometer code encoded to binary count
// - Codes 0 to 255, saturating, never wrapping
// - Invert inputs idle high mean true binary
// - Low invert input complements seven lower bits
// - Top bit inversion alone gives offset twos
// - Step zero codes follow the four modes
`timescale 1ns/100ps
`default_nettype none
module fac_top #(
  parameter int FIFO_DEPTH = fac_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sample_strobe,
  input wire logic [fac_pkg::THERMO_W-1:0] thermo_code,
  input wire logic top_bit_invert_n,
  input wire logic lower_bits_invert_n,
  output logic [fac_pkg::WORD_W-1:0] output_word,
  output logic word_valid,
  input wire logic word_ready,
  output logic [fac_pkg::WORD_W-1:0] word_data
);
  if (FIFO_DEPTH < 2)
  begin
    $error("fac_top needs a FIFO depth of at least 2");
  end

  // ************************************************************
  // Encoder function
  // ************************************************************
  function automatic logic [fac_pkg::WORD_W-1:0] thermo_to_bin(input logic [fac_pkg::THERMO_W-1:0] t);
    logic [fac_pkg::WORD_W-1:0] n;
    n = '0;
    for (int i = 0; i < fac_pkg::THERMO_W; i++)
    begin
      if (t[i])
      begin
        n = fac_pkg::WORD_W'(i + 1);
      end
    end
    return n;
  endfunction

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [2:0] strobe_s1_q;
  logic [2:0] strobe_s2_q;
  logic strobe_prev_q;
  logic [fac_pkg::THERMO_W-1:0] thermo_s1_q;
  logic [fac_pkg::THERMO_W-1:0] thermo_s2_q;
  logic strobe_rise;

  always_ff @(posedge clk)
  begin
    strobe_s1_q <= {lower_bits_invert_n, top_bit_invert_n, sample_strobe};
    strobe_s2_q <= strobe_s1_q;
    thermo_s1_q <= thermo_code;
    thermo_s2_q <= thermo_s1_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      strobe_prev_q <= 1'b1;
    end
    else
    begin
      strobe_prev_q <= strobe_s2_q[0];
    end
  end

  assign strobe_rise = strobe_s2_q[0] && !strobe_prev_q;

  // ************************************************************
  // Sample, encode and output latches
  // ************************************************************
  logic [fac_pkg::WORD_W-1:0] sample_q;
  logic [fac_pkg::WORD_W-1:0] word_q;
  logic [fac_pkg::WORD_W-1:0] coded;

  // Binary count of the high comparators, saturating at full scale
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sample_q <= fac_pkg::WORD_RST;
    end
    else if (strobe_rise)
    begin
      sample_q <= thermo_to_bin(thermo_s2_q);
    end
  end

  // Invert inputs are active low; idle high leaves true binary
  always_comb
  begin
    coded = sample_q;
    if (!strobe_s2_q[1])
    begin
      coded[fac_pkg::TOP_BIT] = ~sample_q[fac_pkg::TOP_BIT];
    end
    if (!strobe_s2_q[2])
    begin
      coded[fac_pkg::LOW_FIELD_W-1:0] = ~sample_q[fac_pkg::LOW_FIELD_W-1:0];
    end
  end

  // Previous sample moves to the output at each strobe edge
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      word_q <= fac_pkg::WORD_RST;
    end
    else if (strobe_rise)
    begin
      word_q <= coded;
    end
  end

  assign output_word = word_q;

  // ************************************************************
  // Output word stream buffer
  // ************************************************************
  logic push_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      push_q <= 1'b0;
    end
    else
    begin
      push_q <= strobe_rise;
    end
  end

  fac_fifo #(
    .WIDTH(fac_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(push_q),
    .in_ready(),
    .in_data(word_q),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  AST_EDGE_ONLY: assert property (@(posedge clk) disable iff (srst)
    !strobe_rise |=> $stable(sample_q))
    else $error("sample changed without strobe edge");

  AST_PIPE: assert property (@(posedge clk) disable iff (srst)
    strobe_rise && !$past(srst) |=> (output_word ==
      (($past(sample_q) ^ {~$past(strobe_s2_q[1]), {7{~$past(strobe_s2_q[2])}}}))))
    else $error("output is not previous sample");

  AST_HOLD: assert property (@(posedge clk) disable iff (srst)
    !strobe_rise |=> $stable(output_word))
    else $error("output word changed between strobes");

  AST_FULL_SCALE: assert property (@(posedge clk) disable iff (srst)
    strobe_rise && thermo_s2_q[fac_pkg::THERMO_W-1] |=> sample_q == fac_pkg::FULL_SCALE)
    else $error("over-range input did not saturate");

  AST_ZERO: assert property (@(posedge clk) disable iff (srst)
    strobe_rise && thermo_s2_q == '0 |=> sample_q == 8'h00)
    else $error("empty thermometer code did not give zero");

  AST_TRUE: assert property (@(posedge clk) disable iff (srst)
    strobe_s2_q[1] && strobe_s2_q[2] |-> coded == sample_q)
    else $error("idle invert inputs altered the word");

  AST_LOW_INV: assert property (@(posedge clk) disable iff (srst)
    !strobe_s2_q[2] |-> coded[6:0] == ~sample_q[6:0] && coded[7] == (sample_q[7] ^ !strobe_s2_q[1]))
    else $error("lower field inversion wrong");

  AST_OFFSET: assert property (@(posedge clk) disable iff (srst)
    !strobe_s2_q[1] && strobe_s2_q[2] && sample_q == 8'h80 |-> coded == 8'h00)
    else $error("offset twos code wrong at mid step");

  AST_STEP0: assert property (@(posedge clk) disable iff (srst)
    sample_q == 8'h00 && !strobe_s2_q[1] && !strobe_s2_q[2] |-> coded == 8'hff)
    else $error("inverted step zero code wrong");

  AST_RISE_ONCE: assert property (@(posedge clk) disable iff (srst)
    strobe_rise |=> !strobe_rise)
    else $error("one strobe edge started two samples");

  AST_LSB: assert property (@(posedge clk) disable iff (srst)
    strobe_rise && thermo_s2_q == 255'h1 |=> sample_q == 8'h01)
    else $error("single high comparator did not give the LSB");

  AST_TOP_ONLY: assert property (@(posedge clk) disable iff (srst)
    !strobe_s2_q[1] && strobe_s2_q[2] |-> coded == {~sample_q[fac_pkg::TOP_BIT], sample_q[fac_pkg::LOW_FIELD_W-1:0]})
    else $error("top bit inversion alone is wrong");

  AST_TOP_KEEP: assert property (@(posedge clk) disable iff (srst)
    strobe_s2_q[1] |-> coded[fac_pkg::TOP_BIT] == sample_q[fac_pkg::TOP_BIT])
    else $error("lower field inversion touched the top bit");

  AST_RESET_OUT: assert property (@(posedge clk)
    srst |=> output_word == fac_pkg::WORD_RST && !word_valid)
    else $error("reset did not clear the outputs");

  AST_STREAM: assert property (@(posedge clk) disable iff (srst)
    strobe_rise |=> push_q && output_word == $past(coded))
    else $error("strobe edge did not present and queue the word");
endmodule
`default_nettype wire

// File: rtl/fac_pkg.sv
// Package of constants for the flash converter output coding block
package fac_pkg;
  localparam int WORD_W = 8;
  localparam int THERMO_W = 255;
  localparam int LOW_FIELD_W = 7;
  localparam int TOP_BIT = 7;
  localparam int PIPE_DEPTH = 1;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic [7:0] FULL_SCALE = 8'hff;
endpackage

// File: rtl/fac_fifo.sv
// Small synchronous FIFO with registered read data
`timescale 1ns/100ps
`default_nettype none
module fac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin
    $error("fac_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [WIDTH-1:0] out_data_q;
  logic out_valid_q;
  logic empty;
  logic full;
  logic pop;

  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready = !full;
  assign pop = !empty && (!out_valid_q || out_ready);
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  // ************************************************************
  // Storage and pointers
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (in_valid && !full)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end
    else
    begin
      if (in_valid && !full)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
        out_data_q <= mem_q[rd_q[AW-1:0]];
        out_valid_q <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/fac_capture.sv
// Capture logic model: strobes the converter, drives levels, takes words
`timescale 1ns/100ps
`default_nettype none
module fac_capture (
  input wire logic clk,
  input wire logic fire,
  input wire logic [7:0] step,
  input wire logic stall,
  output logic sample_strobe,
  output logic [254:0] thermo_code,
  output logic word_ready
);
  logic [2:0] cnt_q = 3'h0;
  // One strobe period: high four cycles, low four
  always_ff @(posedge clk)
  begin
    if (cnt_q != 3'h0 || fire)
      cnt_q <= cnt_q + 3'h1;
  end
  assign sample_strobe = (cnt_q != 3'h0) && (cnt_q < 3'h5);
  assign thermo_code = ~({255{1'b1}} << step);
  assign word_ready = ~stall;
endmodule
`default_nettype wire

// File: testbench/fac_top_bench.sv
// Self-checking bench for the converter coding path
`timescale 1ns/100ps
`default_nettype none
module fac_top_bench;
  logic clk, srst, fire, stall, sample_strobe, word_valid, word_ready;
  logic top_bit_invert_n, lower_bits_invert_n;
  logic [7:0] step, prev, output_word, word_data;
  logic [254:0] thermo_code;
  logic [7:0] exp_q[$];
  logic [7:0] zero_tab [4] = '{8'hff, 8'h80, 8'h7f, 8'h00};
  logic [7:0] step_tab [7] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'h81, 8'hfe, 8'hff};
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  fac_capture PART (.clk(clk), .fire(fire), .step(step), .stall(stall), .sample_strobe(sample_strobe),
    .thermo_code(thermo_code), .word_ready(word_ready));
  fac_top #(.FIFO_DEPTH(8)) DUT (.clk(clk), .srst(srst), .sample_strobe(sample_strobe),
    .thermo_code(thermo_code), .top_bit_invert_n(top_bit_invert_n), .lower_bits_invert_n(lower_bits_invert_n),
    .output_word(output_word), .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] code(input logic [7:0] s);
    return {s[7] ^ ~top_bit_invert_n, s[6:0] ^ {7{~lower_bits_invert_n}}};
  endfunction
  // ***************
  // Scenarios
  // ***************
  task automatic conv(input logic [7:0] s);
    logic [7:0] e;
    e = code(prev);
    step = s;
    repeat (3) tick();
    fire = 1'b1;
    tick();
    fire = 1'b0;
    repeat (10) tick();
    prev = s;
    exp_q.push_back(e);
    chk("output_word", e, output_word);
  endtask
  task automatic test_steps();
    foreach (step_tab[i])
      conv(step_tab[i]);
    conv(8'h00);
  endtask
  task automatic test_modes();
    for (int m = 0; m < 4; m++)
    begin
      {top_bit_invert_n, lower_bits_invert_n} = m[1:0];
      conv(8'h00);
      conv(8'h80);
      chk("step zero", zero_tab[m], output_word);
      conv(8'h80);
    end
    {top_bit_invert_n, lower_bits_invert_n} = 2'b11;
    conv(8'h3c);
  endtask
  task automatic test_hold();
    conv(8'h5a);
    conv(8'ha5);
    step = 8'hc3;
    repeat (24) tick();
    chk("held word", 8'h5a, output_word);
    conv(8'h00);
  endtask
  task automatic test_reset();
    stall = 1'b1;
    conv(8'h42);
    chk("word_valid", 8'h01, {7'h00, word_valid});
    srst = 1'b1;
    repeat (2) tick();
    srst = 1'b0;
    tick();
    chk("reset word", 8'h00, output_word);
    chk("word_valid", 8'h00, {7'h00, word_valid});
    chk("word_data", 8'h00, word_data);
    prev = 8'h00;
    stall = 1'b0;
    conv(8'h24);
  endtask
  task automatic test_fifo();
    exp_q.delete();
    stall = 1'b1;
    for (int i = 0; i < 8; i++)
      conv(8'h11 * i[7:0]);
    for (int i = 0; i < 8; i++)
    begin
      for (int k = 0; k < 20 && word_valid !== 1'b1; k++)
        tick();
      chk("word_data", exp_q.pop_front(), word_data);
      stall = 1'b0;
      tick();
      stall = 1'b1;
      repeat (3) tick();
    end
    chk("word_valid", 8'h00, {7'h00, word_valid});
    stall = 1'b0;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    {srst, top_bit_invert_n, lower_bits_invert_n} = 3'b111;
    {fire, stall, step, prev} = '0;
    repeat (20) tick();
    srst = 1'b0;
    tick();
    chk("reset word", 8'h00, output_word);
    chk("word_valid", 8'h00, {7'h00, word_valid});
    chk("word_data", 8'h00, word_data);
    test_steps();
    test_modes();
    test_hold();
    test_fifo();
    test_reset();
    end_sim();
  end
endmodule
`default_nettype wire
